// ---- frp_regs.sv ----
/*
 flash remap / protection register bank, AHB-Lite slave, zero wait states.
 assumes protection and shadow straps come from the config row loader
 and busy flags from the flash banks, all asynchronous to hclk.
*/
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module frp_regs #(
    parameter int FAB_ADDR_W = 19
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [FAB_ADDR_W-1:0] fab_addr,
    output logic [FAB_ADDR_W-1:0] flash_addr,
    input wire logic [15:0] cfg_row_prot,
    input wire logic cfg_row_shadow,
    input wire logic cfg_row_valid,
    input wire logic [1:0] bank_busy_in,
    output logic [15:0] region_perm,
    output logic shadow_request,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for asynchronous inputs
    // only the second stage of each pair is read; the first may go metastable

    logic [15:0] prot_s1_reg;
    logic [15:0] prot_s2_reg;
    logic shadow_s1_reg;
    logic shadow_s2_reg;
    logic valid_s1_reg;
    logic valid_s2_reg;
    logic [1:0] busy_s1_reg;
    logic [1:0] busy_s2_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prot_s1_reg <= frp_pkg::FRP_PROT_RESET;
            prot_s2_reg <= frp_pkg::FRP_PROT_RESET;
            shadow_s1_reg <= 1'b0;
            shadow_s2_reg <= 1'b0;
            valid_s1_reg <= 1'b0;
            valid_s2_reg <= 1'b0;
            busy_s1_reg <= frp_pkg::FRP_BUSY_RESET;
            busy_s2_reg <= frp_pkg::FRP_BUSY_RESET;
        end
        else
        begin
            prot_s1_reg <= cfg_row_prot;
            prot_s2_reg <= prot_s1_reg;
            shadow_s1_reg <= cfg_row_shadow;
            shadow_s2_reg <= shadow_s1_reg;
            valid_s1_reg <= cfg_row_valid;
            valid_s2_reg <= valid_s1_reg;
            busy_s1_reg <= bank_busy_in;
            busy_s2_reg <= busy_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite address phase capture

    frp_pkg::frp_addr_phase_s ap_reg;
    logic ap_valid_reg;
    logic ap_take;

    assign ap_take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_reg <= '0;
            ap_valid_reg <= 1'b0;
        end
        else if (hready)
        begin
            ap_valid_reg <= ap_take;
            ap_reg <= '{htrans: htrans, hwrite: hwrite, hsize: hsize, addr: haddr[7:0]};
        end
    end

    function automatic logic hit(input frp_pkg::frp_addr_phase_s ap, input logic [7:0] ofs);
        hit = (ap.addr[7:2] == ofs[7:2]);
    endfunction : hit

    logic wr_en;
    logic wr_remap;
    logic wr_irq_status;
    logic wr_irq_mask;
    assign wr_en = ap_valid_reg && ap_reg.hwrite;
    assign wr_remap = wr_en && hit(ap_reg, frp_pkg::FRP_OFS_REMAP);
    assign wr_irq_status = wr_en && hit(ap_reg, frp_pkg::FRP_OFS_IRQ_STATUS);
    assign wr_irq_mask = wr_en && hit(ap_reg, frp_pkg::FRP_OFS_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // fabric remap control

    logic [31:0] remap_reg;
    logic fabric_remap_on;
    logic [frp_pkg::FRP_BASE_W-1:0] fabric_remap_base;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            remap_reg <= frp_pkg::FRP_REMAP_RESET;
        else if (wr_remap)
            remap_reg <= hwdata & frp_pkg::FRP_REMAP_MASK;
    end

    assign fabric_remap_on = remap_reg[0];
    assign fabric_remap_base = remap_reg[frp_pkg::FRP_BASE_LSB +: frp_pkg::FRP_BASE_W];

    // base is a byte offset with bit 0 implied zero; adder wraps within flash space
    logic [FAB_ADDR_W-1:0] base_ofs;
    assign base_ofs = FAB_ADDR_W'({fabric_remap_base, 1'b0});

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flash_addr <= '0;
        else if (fabric_remap_on)
            flash_addr <= FAB_ADDR_W'(fab_addr + base_ofs);
        else
            flash_addr <= fab_addr;
    end

    ////////////////////////////////////////////////////////////////////////
    // protection, boot shadow, busy

    logic [15:0] perm_reg;
    logic boot_reg;
    logic [1:0] bank_busy_flags;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            perm_reg <= frp_pkg::FRP_PROT_RESET;
        else if (valid_s2_reg)
            perm_reg <= prot_s2_reg & frp_pkg::FRP_PROT_MASK;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            boot_reg <= 1'b0;
        else if (valid_s2_reg)
            boot_reg <= shadow_s2_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bank_busy_flags <= frp_pkg::FRP_BUSY_RESET;
        else
            bank_busy_flags <= busy_s2_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            region_perm <= frp_pkg::FRP_PROT_RESET;
            shadow_request <= 1'b0;
        end
        else
        begin
            region_perm <= perm_reg;
            shadow_request <= boot_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: busy done per bank, permission load, shadow request

    logic [1:0] busy_prev_reg;
    logic [3:0] irq_status_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] irq_event;
    logic [3:0] irq_status_next;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            busy_prev_reg <= frp_pkg::FRP_BUSY_RESET;
        else
            busy_prev_reg <= bank_busy_flags;
    end

    // bit 3 follows the row being loaded, not the boot copy from an older load
    assign irq_event = {shadow_s2_reg & valid_s2_reg, valid_s2_reg,
                        busy_prev_reg & ~bank_busy_flags};

    // set wins over a write-one clear in the same cycle
    assign irq_status_next = wr_irq_status
        ? ((irq_status_reg & ~hwdata[3:0]) | irq_event)
        : (irq_status_reg | irq_event);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_status_reg <= frp_pkg::FRP_IRQ_RESET;
        else
            irq_status_reg <= irq_status_next;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_mask_reg <= frp_pkg::FRP_IRQ_RESET;
        else if (wr_irq_mask)
            irq_mask_reg <= hwdata[3:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= |(irq_status_reg & irq_mask_reg);
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered in the address phase

    // a read right behind a write returns the value that write lands
    logic [31:0] remap_view;
    logic [3:0] mask_view;
    assign remap_view = wr_remap ? (hwdata & frp_pkg::FRP_REMAP_MASK) : remap_reg;
    assign mask_view = wr_irq_mask ? hwdata[3:0] : irq_mask_reg;

    logic [31:0] rd_next;

    always_comb
    begin
        rd_next = 32'h00000000;
        case (haddr[7:0] & 8'hFC)
            frp_pkg::FRP_OFS_REMAP: rd_next = remap_view;
            frp_pkg::FRP_OFS_PROTECT: rd_next = {16'h0000, perm_reg};
            frp_pkg::FRP_OFS_BOOT: rd_next = {31'h0, boot_reg};
            frp_pkg::FRP_OFS_BUSY: rd_next = {30'h0, bank_busy_flags};
            frp_pkg::FRP_OFS_IRQ_STATUS: rd_next = {28'h0, irq_status_next};
            frp_pkg::FRP_OFS_IRQ_MASK: rd_next = {28'h0, mask_view};
            default: rd_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (ap_take && !hwrite)
            hrdata <= rd_next;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_cfg_load;
        valid_s2_reg ##1 1'b1;
    endsequence

    sequence s_read_busy;
        ap_take && !hwrite && ((haddr[7:0] & 8'hFC) == frp_pkg::FRP_OFS_BUSY);
    endsequence

    sequence s_read_remap;
        ap_take && !hwrite && ((haddr[7:0] & 8'hFC) == frp_pkg::FRP_OFS_REMAP);
    endsequence

    a_remap_off_pass: assert property (@(posedge hclk) disable iff (!hresetn)
        !fabric_remap_on |=> flash_addr == $past(fab_addr))
        else $error("flash address not identity with remap off");
    a_remap_on_offset: assert property (@(posedge hclk) disable iff (!hresetn)
        fabric_remap_on |=> flash_addr == FAB_ADDR_W'($past(fab_addr) + $past(base_ofs)))
        else $error("remapped flash address wrong");
    a_remap_write_effect: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_en && hit(ap_reg, frp_pkg::FRP_OFS_REMAP) |=> fabric_remap_on == $past(hwdata[0]))
        else $error("remap enable not written");
    a_remap_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        remap_reg[31:19] == 13'h0)
        else $error("reserved remap bits set");
    a_perm_load: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cfg_load |-> perm_reg == ($past(prot_s2_reg) & frp_pkg::FRP_PROT_MASK))
        else $error("permissions not loaded from config row");
    a_perm_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !valid_s2_reg |=> $stable(perm_reg))
        else $error("permissions changed without config load");
    a_perm_out: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> region_perm == $past(perm_reg))
        else $error("permission output lags wrongly");
    a_perm_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
        (perm_reg & ~frp_pkg::FRP_PROT_MASK) == 16'h0000)
        else $error("reserved permission bit set");
    a_shadow_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        valid_s2_reg |=> ##1 shadow_request == $past(shadow_s2_reg, 2))
        else $error("shadow request not propagated");
    a_busy_track: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(busy_s2_reg[0]) |=> bank_busy_flags[0])
        else $error("bank busy not reported");
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        |(irq_status_reg & irq_mask_reg) |=> irq)
        else $error("interrupt not raised");
    a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("bus response not zero-wait okay");
    a_read_busy: assert property (@(posedge hclk) disable iff (!hresetn)
        s_read_busy |=> hrdata == {30'h0, $past(bank_busy_flags)})
        else $error("busy read data wrong");
    a_read_remap: assert property (@(posedge hclk) disable iff (!hresetn)
        s_read_remap |=> hrdata == remap_reg)
        else $error("remap read data stale");
    a_remap_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_remap |=> $stable(remap_reg))
        else $error("remap register changed without write");
    a_busy_rise1: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(busy_s2_reg[1]) |=> bank_busy_flags[1])
        else $error("bank 1 busy not reported");
    a_busy_fall0: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(busy_s2_reg[0]) |=> !bank_busy_flags[0])
        else $error("bank 0 busy not released");
    a_busy_fall1: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(busy_s2_reg[1]) |=> !bank_busy_flags[1])
        else $error("bank 1 busy not released");
    a_boot_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !valid_s2_reg |=> $stable(boot_reg))
        else $error("boot status changed without config load");
    a_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_irq_mask |=> irq_mask_reg == $past(hwdata[3:0]))
        else $error("interrupt mask not written");
    a_irq_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_irq_status |=> (irq_status_reg & $past(irq_status_reg)) == $past(irq_status_reg))
        else $error("status bit lost without clear");
    a_irq_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        (|irq_event) |=> (irq_status_reg & $past(irq_event)) == $past(irq_event))
        else $error("event not recorded in status");
    a_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|(irq_status_reg & irq_mask_reg)) |=> !irq)
        else $error("interrupt raised with nothing pending");

endmodule : frp_regs

// ---- frp_pkg.sv ----
/*
 flash remap / protection register bank: offsets, layouts, reset values.
 assumes a 32-bit AHB-Lite register port, one word per register.
*/
package frp_pkg;

    localparam logic [7:0] FRP_OFS_REMAP = 8'h00;
    localparam logic [7:0] FRP_OFS_PROTECT = 8'h04;
    localparam logic [7:0] FRP_OFS_BOOT = 8'h08;
    localparam logic [7:0] FRP_OFS_BUSY = 8'h0C;
    localparam logic [7:0] FRP_OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] FRP_OFS_IRQ_MASK = 8'h14;

    localparam int FRP_BASE_LSB = 1;
    localparam int FRP_BASE_W = 18;
    localparam int FRP_ADDR_W = 19;
    localparam logic [31:0] FRP_REMAP_MASK = 32'h0007FFFF;
    localparam logic [31:0] FRP_REMAP_RESET = 32'h00000000;
    localparam logic [15:0] FRP_PROT_MASK = 16'hEEEE;
    localparam logic [15:0] FRP_PROT_RESET = 16'hEEEE;
    localparam logic [31:0] FRP_BOOT_RESET = 32'h00000000;
    localparam logic [1:0] FRP_BUSY_RESET = 2'h0;
    localparam logic [3:0] FRP_IRQ_RESET = 4'h0;

    // interrupt status bits: busy falling per bank, protection load, shadow request
    localparam int FRP_IRQ_W = 4;

    typedef struct packed {
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [7:0] addr;
    } frp_addr_phase_s;

endpackage : frp_pkg

// ---- frp_far.sv ----
/*
 far side of the flash register bank: config row loader and two flash banks.
 assumes load and op are single-cycle pulses driven off the hclk rising edge.
*/
`timescale 1ns/1ps
module frp_far #(
    parameter int LEN0 = 12,
    parameter int LEN1 = 40
) (
    input wire logic hclk,
    input wire logic load,
    input wire logic [15:0] prot,
    input wire logic shad,
    input wire logic [1:0] op,
    output logic [15:0] cfg_row_prot,
    output logic cfg_row_shadow,
    output logic cfg_row_valid,
    output logic [1:0] bank_busy_in
);
    logic [15:0] p = 16'h0000;
    logic s = 1'b0;
    int hold = 0;
    int c0 = 0;
    int c1 = 0;
    ////////////////////////////////////////////////////////////////
    // row lines outside a load show inverted data, never a stale copy
    assign cfg_row_valid = hold > 0;
    assign cfg_row_prot = cfg_row_valid ? p : ~p;
    assign cfg_row_shadow = cfg_row_valid ? s : ~s;
    // bank 0 answers promptly, bank 1 slowly
    assign bank_busy_in = {c1 > 0, c0 > 0};
    always @(posedge hclk)
    begin
        if (load)
        begin
            p <= prot;
            s <= shad;
            hold <= 4;
        end
        else if (hold > 0)
            hold <= hold - 1;
        if (op[0])
            c0 <= LEN0;
        else if (c0 > 0)
            c0 <= c0 - 1;
        if (op[1])
            c1 <= LEN1;
        else if (c1 > 0)
            c1 <= c1 - 1;
    end
endmodule : frp_far

// ---- testbench.sv ----
/*
 self-checking bench for the flash register bank against an integer model.
 assumes zero-wait AHB-Lite slave, hready looped from hreadyout.
*/
`timescale 1ns/1ps
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, shadow_request, irq, cfg_row_shadow, cfg_row_valid;
    logic load = 1'b0;
    logic shad = 1'b0;
    logic [18:0] fab_addr = 19'h0;
    logic [18:0] flash_addr;
    logic [15:0] cfg_row_prot, region_perm;
    logic [15:0] prot = 16'h0;
    logic [1:0] bank_busy_in;
    logic [1:0] op = 2'h0;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 35352;
    int m_remap = 0, m_perm = 'hEEEE, m_shad = 0, m_busy = 0, m_irq = 0, m_mask = 0;
    logic [31:0] r;
    logic [31:0] v;

    always #10 hclk = ~hclk;

    frp_regs #(.FAB_ADDR_W(19)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fab_addr(fab_addr), .flash_addr(flash_addr), .cfg_row_prot(cfg_row_prot),
        .cfg_row_shadow(cfg_row_shadow), .cfg_row_valid(cfg_row_valid),
        .bank_busy_in(bank_busy_in), .region_perm(region_perm),
        .shadow_request(shadow_request), .irq(irq));
    frp_far far (.hclk(hclk), .load(load), .prot(prot), .shad(shad), .op(op),
        .cfg_row_prot(cfg_row_prot), .cfg_row_shadow(cfg_row_shadow),
        .cfg_row_valid(cfg_row_valid), .bank_busy_in(bank_busy_in));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rexp(input int a);
        case (a)
            0: return m_remap;
            4: return m_perm;
            8: return m_shad;
            12: return m_busy;
            16: return m_irq;
            20: return m_mask;
            default: return 32'h0;
        endcase
    endfunction : rexp

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic rd(input int a, input logic [31:0] e);
        bus(1'b0, a[7:0], $random(seed));
        chk(r, e);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    task automatic finish_test;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    initial
    begin
        #(20 * 5000);
        miscompares++;
        finish_test;
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        idle(3);
        hresetn <= 1'b1;
        chk({16'h0, region_perm}, 32'hEEEE);
        chk({13'h0, flash_addr}, 32'h0);
        // read-only and unmapped places must ignore writes
        foreach (v[i]) if (i < 8 && i != 0 && i != 4 && i != 5) bus(1'b1, 8'(i * 4), '1);
        for (int a = 0; a < 32; a += 4) rd(a, rexp(a));
        $display("reset and reserved test done");
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 7) ? '1 : $random(seed);
            v[0] = i[0] | (i == 7);
            bus(1'b1, 8'h00, v);
            m_remap = v & 32'h7FFFF;
            rd(0, m_remap);
            repeat (4)
            begin
                @(posedge hclk) fab_addr <= 19'($random(seed));
                @(posedge hclk);
                #1;
                v = (fab_addr + (m_remap[0] ? (m_remap & 32'h7FFFE) : 0)) & 32'h7FFFF;
                chk({13'h0, flash_addr}, v);
            end
        end
        $display("remap test done");
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b1, 8'h10, 32'hF);
            @(posedge hclk);
            prot <= 16'($random(seed));
            shad <= !i[0];
            load <= 1'b1;
            @(posedge hclk) load <= 1'b0;
            m_perm = prot & 16'hEEEE;
            m_shad = !i[0];
            m_irq = m_shad ? 12 : 4;
            idle(12);
            chk({16'h0, region_perm}, m_perm);
            chk({31'h0, shadow_request}, m_shad);
            for (int a = 4; a < 20; a += 4) rd(a, rexp(a));
        end
        bus(1'b1, 8'h14, 32'h4);
        m_mask = 4;
        idle(2);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 8'h10, 32'h4);
        m_irq = 0;
        idle(2);
        chk({31'h0, irq}, 32'h0);
        $display("config load test done");
        @(posedge hclk) op <= 2'h3;
        @(posedge hclk) op <= 2'h0;
        idle(4);
        rd(12, 32'h3);
        idle(20);
        rd(12, 32'h2);
        rd(16, 32'h1);
        chk({31'h0, irq}, 32'h0);
        idle(40);
        rd(12, 32'h0);
        bus(1'b1, 8'h14, 32'h3);
        idle(2);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 8'h10, 32'h1);
        idle(2);
        chk({31'h0, irq}, 32'h1);
        rd(16, 32'h2);
        bus(1'b1, 8'h10, 32'h2);
        idle(2);
        chk({31'h0, irq}, 32'h0);
        $display("busy and interrupt test done");
        finish_test;
    end
endmodule : testbench
